// [core/tlv_cmd_pkg.sv]
// Purpose: constants shared by the card-side toolkit and object transfer decoder
// Assumes: byte-wide command units already framed by an outer link layer
// Notes:   status words and command classes are named once here
package tlv_cmd_pkg;
   // =====================================================================
   // Command classes
   // =====================================================================
   typedef enum logic [2:0] {
      CMD_PROFILE   = 3'h0,
      CMD_ENVELOPE  = 3'h1,
      CMD_FETCH     = 3'h2,
      CMD_TERM_RESP = 3'h3,
      CMD_RETRIEVE  = 3'h4,
      CMD_STORE     = 3'h5,
      CMD_SELECT    = 3'h6,
      CMD_OTHER     = 3'h7
   } cmd_kind_t;

   // =====================================================================
   // Block selector in the second parameter byte
   // =====================================================================
   localparam logic [1:0] BLK_FIRST  = 2'h2;
   localparam logic [1:0] BLK_NEXT   = 2'h0;
   localparam logic [1:0] BLK_RETX   = 2'h1;
   localparam int         BLK_POS    = 6;
   localparam logic [4:0] SFI_CUR    = 5'h00;

   // =====================================================================
   // Parameter, tag and length codes
   // =====================================================================
   localparam logic [7:0] PARAM_ZERO    = 8'h00;
   localparam logic [7:0] TAG_LIST      = 8'h5C;
   localparam logic [7:0] TAG_PRIM_LO   = 8'h80;
   localparam logic [7:0] TAG_PRIM_HI   = 8'h9E;
   localparam logic [7:0] TAG_PRIM_EXT  = 8'h9F;
   localparam logic [7:0] TAG_CONS_LO   = 8'hA0;
   localparam logic [7:0] TAG_CONS_HI   = 8'hBE;
   localparam logic [7:0] TAG_CONS_EXT  = 8'hBF;
   localparam logic [7:0] TAG2_LO       = 8'h1F;
   localparam logic [7:0] TAG2_HI       = 8'h7F;
   localparam logic [7:0] TAG3_MID_LO   = 8'h81;
   localparam logic [7:0] TAG3_LAST_HI  = 8'h7F;
   localparam logic [7:0] LEN_SHORT_MAX = 8'h7F;
   localparam logic [7:0] LEN_LONG1     = 8'h81;
   localparam logic [7:0] LEN_LONG2     = 8'h82;
   localparam logic [7:0] LEN_LONG3     = 8'h83;

   // =====================================================================
   // Status words
   // =====================================================================
   localparam logic [15:0] SW_OK         = 16'h9000;
   localparam logic [15:0] SW_MORE_AVL   = 16'h62F1;
   localparam logic [15:0] SW_MORE_AVL_P = 16'h62F2;
   localparam logic [15:0] SW_MORE_EXP   = 16'h63F1;
   localparam logic [15:0] SW_MORE_EXP_P = 16'h63F2;
   localparam logic [15:0] SW_DONE_NEXT  = 16'h6A86;
   localparam logic [15:0] SW_BAD_DATA   = 16'h6A80;
   localparam logic [15:0] SW_BAD_P1P2   = 16'h6B00;
   localparam logic [15:0] SW_NO_INS     = 16'h6D00;
   localparam logic [15:0] SW_NO_STATE   = 16'h6985;
   localparam logic [15:0] SW_WRONG_LEN  = 16'h6700;
endpackage : tlv_cmd_pkg

// [core/byte_fifo.sv]
// Purpose: small synchronous FIFO with valid and ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             mclk_in,
   input  wire logic             nrst_in,
   // Fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("byte_fifo: depth must be a power of two of at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign in_ready_out  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_ptr != rd_ptr;
   assign out_data_out  = mem[rd_ptr[AW-1:0]];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

   a_no_overfill: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (wr_ptr - rd_ptr) <= (AW+1)'(DEPTH))
      else $error("fifo holds more than its depth");
endmodule : byte_fifo
`default_nettype wire

// [core/tlv_cmd_decoder.sv]
// Purpose: card-side decoder for toolkit commands and segmented object transfer
// Assumes: command header arrives as one strobe, data bytes stream after it
// Notes:   per-channel tag pointer and offset; toolkit payload passes a FIFO
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Envelope needs both parameter bytes zero
// - Fetch: zero params, no data, answers 9000
// - Response and profile: zero params, data present
// - Unsupported command gets status, not executed
// - Object framed tag, length, value
// - Primitive tags only from context ranges
// - Constructed tags only from context ranges
// - Tag list request on retrieve raises tag_list_out
// - Length forms short, 81, 82, 83
// - Length must be shortest encoding
// - Transfer state kept per logical channel
// - First block starts, next blocks continue
// - Non-final block answers more data
// - File or pointer change aborts transfer
// - Good first block sets pointer, aborts old
// - Error status leaves pointer and offset
// - Retransmit only after success, same params
// - Retrieve answers 62F1 or 62F2 mid-object
// - Store answers 63F1/63F2, then 9000
// - Next after completion answers 6A86
module tlv_cmd_decoder
   import tlv_cmd_pkg::*;
#(
   parameter int CHANNELS   = 4,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic                        mclk_in,
   input  wire logic                        nrst_in,
   // Command header
   input  wire logic                        cmd_valid_in,
   input  wire cmd_kind_t                   cmd_kind_in,
   input  wire logic [$clog2(CHANNELS)-1:0] cmd_chan_in,
   input  wire logic [7:0]                  cmd_p1_in,
   input  wire logic [7:0]                  cmd_p2_in,
   input  wire logic                        cmd_has_lc_in,
   input  wire logic [7:0]                  cmd_lc_in,
   input  wire logic                        cmd_has_le_in,
   input  wire logic                        cmd_app_ok_in,
   input  wire logic                        proactive_pending_in,
   // Command data bytes
   input  wire logic                        data_valid_in,
   output logic                             data_ready_out,
   input  wire logic [7:0]                  data_in,
   // Toolkit payload out
   output logic                             kit_valid_out,
   input  wire logic                        kit_ready_in,
   output logic [7:0]                       kit_data_out,
   // Status answer
   output logic                             sw_valid_out,
   output logic [15:0]                      sw_out,
   output logic [23:0]                      obj_tag_out,
   output logic [23:0]                      obj_len_out,
   output logic                             obj_constructed_out,
   output logic                             tag_list_out
);
   localparam int CW = $clog2(CHANNELS);

   initial begin
      if (CHANNELS < 2 || (1 << CW) != CHANNELS) begin
         $error("tlv_cmd_decoder: channel count must be a power of two");
      end
   end

   // ======================================================================
   // Tag and length checks
   // ======================================================================
   function automatic logic tag_ok(input logic [23:0] t, input logic [1:0] n);
      logic [7:0] b0;
      b0 = t[23:16];
      case (n)
         2'd1:    tag_ok = (b0 >= TAG_PRIM_LO && b0 <= TAG_PRIM_HI) ||
                           (b0 >= TAG_CONS_LO && b0 <= TAG_CONS_HI);
         2'd2:    tag_ok = (b0 == TAG_PRIM_EXT || b0 == TAG_CONS_EXT) &&
                           t[15:8] >= TAG2_LO && t[15:8] <= TAG2_HI;
         2'd3:    tag_ok = (b0 == TAG_PRIM_EXT || b0 == TAG_CONS_EXT) &&
                           t[15:8] >= TAG3_MID_LO && t[7:0] <= TAG3_LAST_HI;
         default: tag_ok = 1'b0;
      endcase
   endfunction : tag_ok

   function automatic logic len_short_ok(input logic [7:0] pfx, input logic [23:0] v);
      case (pfx)
         LEN_LONG1: len_short_ok = v[7];
         LEN_LONG2: len_short_ok = v[15:8] != 8'h00;
         LEN_LONG3: len_short_ok = v[23:16] != 8'h00;
         default:   len_short_ok = pfx <= LEN_SHORT_MAX;
      endcase
   endfunction : len_short_ok

   // ======================================================================
   // Sequencer
   // ======================================================================
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_TAG   = 3'b001,
      ST_LEN   = 3'b011,
      ST_VALUE = 3'b010,
      ST_KIT   = 3'b110,
      ST_ANS   = 3'b111
   } state_t;

   state_t      state;
   logic [15:0] next_sw;
   logic        fifo_ready;
   logic        byte_take;
   logic [7:0]  cnt;
   logic [23:0] tag;
   logic [1:0]  tag_n;
   logic [7:0]  len_pfx;
   logic [23:0] len_val;
   logic [1:0]  len_left;
   logic        obj_err;
   logic        kit_err;
   logic        first_blk;
   logic [1:0]  blk;
   logic [CW-1:0] ch;
   cmd_kind_t   kind;
   logic [7:0]  p2_q;
   logic [7:0]  vcnt;

   // Per-channel transfer context
   logic [23:0] ctx_tag    [CHANNELS];
   logic [23:0] ctx_len    [CHANNELS];
   logic [23:0] ctx_off    [CHANNELS];
   logic        ctx_active [CHANNELS];
   logic        ctx_done   [CHANNELS];
   logic        ctx_ok     [CHANNELS];

   assign blk            = cmd_p2_in[BLK_POS+1:BLK_POS];
   assign byte_take      = data_valid_in && data_ready_out;
   assign data_ready_out = (state == ST_TAG) || (state == ST_LEN) ||
                           (state == ST_VALUE) || (state == ST_KIT && fifo_ready);

   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_kit_fifo (
      .mclk_in       (mclk_in),
      .nrst_in       (nrst_in),
      .in_valid_in   (state == ST_KIT && data_valid_in && !kit_err),
      .in_ready_out  (fifo_ready),
      .in_data_in    (data_in),
      .out_valid_out (kit_valid_out),
      .out_ready_in  (kit_ready_in),
      .out_data_out  (kit_data_out)
   );

   // Header checks, decided in the header cycle
   logic hdr_params_zero;
   logic hdr_kit_bad;
   assign hdr_params_zero = cmd_p1_in == PARAM_ZERO && cmd_p2_in == PARAM_ZERO;
   always_comb begin
      case (cmd_kind_in)
         CMD_ENVELOPE:  hdr_kit_bad = !hdr_params_zero || !cmd_has_lc_in;
         CMD_FETCH:     hdr_kit_bad = !hdr_params_zero || cmd_has_lc_in;
         CMD_PROFILE,
         CMD_TERM_RESP: hdr_kit_bad = !hdr_params_zero || !cmd_has_lc_in ||
                                      cmd_has_le_in;
         default:       hdr_kit_bad = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: if (cmd_valid_in) begin
               if (!cmd_app_ok_in || cmd_kind_in == CMD_OTHER) begin
                  state <= ST_ANS;
               end else if (cmd_kind_in <= CMD_TERM_RESP) begin
                  state <= (cmd_has_lc_in && cmd_lc_in != 8'h00) ? ST_KIT : ST_ANS;
               end else if (cmd_kind_in != CMD_SELECT && blk == BLK_FIRST &&
                            cmd_has_lc_in && cmd_lc_in != 8'h00) begin
                  state <= ST_TAG;
               end else if (cmd_has_lc_in && cmd_lc_in != 8'h00) begin
                  state <= ST_VALUE;
               end else begin
                  state <= ST_ANS;
               end
            end
            ST_TAG: if (byte_take) begin
               if (cnt == 8'd1) begin
                  state <= ST_ANS;
               end else if (tag_n == 2'd0 ? (data_in[4:0] != 5'h1F) :
                            (tag_n == 2'd2 || !data_in[7])) begin
                  state <= ST_LEN;
               end
            end
            ST_LEN: if (byte_take) begin
               if (cnt == 8'd1 || (len_left == 2'd1) ||
                   (len_pfx == 8'h00 && data_in <= LEN_SHORT_MAX)) begin
                  state <= (cnt == 8'd1) ? ST_ANS : ST_VALUE;
               end
            end
            ST_VALUE: if (byte_take && cnt == 8'd1) begin
               state <= ST_ANS;
            end
            ST_KIT: if (byte_take && cnt == 8'd1) begin
               state <= ST_ANS;
            end
            ST_ANS:  state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Command capture
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         kind      <= CMD_OTHER;
         ch        <= '0;
         p2_q      <= 8'h00;
         first_blk <= 1'b0;
         kit_err   <= 1'b0;
      end else if (state == ST_IDLE && cmd_valid_in) begin
         kind      <= cmd_app_ok_in ? cmd_kind_in : CMD_OTHER;
         ch        <= cmd_chan_in;
         p2_q      <= cmd_p2_in;
         first_blk <= blk == BLK_FIRST;
         kit_err   <= hdr_kit_bad;
      end
   end

   // Byte counter and object header parse
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         cnt      <= 8'h00;
         tag      <= 24'h0;
         tag_n    <= 2'd0;
         len_pfx  <= 8'h00;
         len_val  <= 24'h0;
         len_left <= 2'd0;
         obj_err  <= 1'b0;
         vcnt     <= 8'h00;
      end else if (state == ST_IDLE && cmd_valid_in) begin
         cnt      <= cmd_lc_in;
         tag      <= 24'h0;
         tag_n    <= 2'd0;
         len_pfx  <= 8'h00;
         len_val  <= 24'h0;
         len_left <= 2'd0;
         obj_err  <= 1'b0;
         vcnt     <= 8'h00;
      end else if (byte_take) begin
         cnt <= cnt - 8'd1;
         vcnt <= vcnt + 8'(state == ST_VALUE);
         if (state == ST_TAG) begin
            tag   <= {tag[15:0], data_in};
            tag_n <= tag_n + 2'd1;
         end else if (state == ST_LEN) begin
            if (len_left == 2'd0 && len_pfx == 8'h00) begin
               len_pfx <= data_in;
               if (data_in <= LEN_SHORT_MAX) begin
                  len_val <= {16'h0, data_in};
               end else if (data_in == LEN_LONG1 || data_in == LEN_LONG2 ||
                            data_in == LEN_LONG3) begin
                  len_left <= data_in[1:0];
               end else begin
                  obj_err <= 1'b1;
               end
            end else begin
               len_val  <= {len_val[15:0], data_in};
               len_left <= len_left - 2'd1;
            end
         end
      end
   end

   // ======================================================================
   // Answer decision
   // ======================================================================
   logic        tag_good;
   logic        is_list;
   logic        len_good;
   logic [23:0] full_tag;
   logic [23:0] new_off;
   assign full_tag = tag << (8 * (3 - tag_n));
   assign is_list  = tag_n == 2'd1 && tag[7:0] == TAG_LIST;
   assign tag_good = tag_ok(full_tag, tag_n) || (is_list && kind == CMD_RETRIEVE);
   assign len_good = !obj_err && len_left == 2'd0 &&
                     len_short_ok(len_pfx, len_val);
   assign new_off  = ctx_off[ch] + 24'(vcnt);

   always_comb begin
      next_sw = SW_OK;
      if (kind == CMD_OTHER) begin
         next_sw = SW_NO_INS;
      end else if (kind <= CMD_TERM_RESP) begin
         next_sw = kit_err ? SW_BAD_P1P2 : SW_OK;
      end else if (kind == CMD_SELECT) begin
         next_sw = SW_OK;
      end else if (p2_q[4:0] != SFI_CUR && !first_blk) begin
         next_sw = SW_BAD_P1P2;
      end else if (first_blk) begin
         if (tag_n == 2'd0 || !tag_good) begin
            next_sw = SW_BAD_DATA;
         end else if (kind == CMD_STORE && !len_good) begin
            next_sw = SW_BAD_DATA;
         end else if (kind == CMD_STORE) begin
            next_sw = (len_val <= 24'(vcnt)) ? SW_OK :
                      (proactive_pending_in ? SW_MORE_EXP_P : SW_MORE_EXP);
         end else begin
            next_sw = proactive_pending_in ? SW_MORE_AVL_P : SW_MORE_AVL;
         end
      end else if (p2_q[BLK_POS+1:BLK_POS] == BLK_RETX) begin
         next_sw = (ctx_ok[ch] && ctx_active[ch]) ? SW_OK : SW_NO_STATE;
      end else if (ctx_done[ch]) begin
         next_sw = SW_DONE_NEXT;
      end else if (!ctx_active[ch]) begin
         next_sw = SW_NO_STATE;
      end else if (new_off >= ctx_len[ch]) begin
         next_sw = SW_OK;
      end else if (kind == CMD_STORE) begin
         next_sw = proactive_pending_in ? SW_MORE_EXP_P : SW_MORE_EXP;
      end else begin
         next_sw = proactive_pending_in ? SW_MORE_AVL_P : SW_MORE_AVL;
      end
   end

   logic ans_err;
   assign ans_err = next_sw[15:8] != 8'h90 && next_sw[15:8] != 8'h62 &&
                    next_sw[15:8] != 8'h63;

   // Per-channel context update
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < CHANNELS; i++) begin
            ctx_tag[i]    <= 24'h0;
            ctx_len[i]    <= 24'h0;
            ctx_off[i]    <= 24'h0;
            ctx_active[i] <= 1'b0;
            ctx_done[i]   <= 1'b0;
            ctx_ok[i]     <= 1'b0;
         end
      end else if (state == ST_ANS && kind != CMD_OTHER && kind > CMD_TERM_RESP) begin
         ctx_ok[ch] <= !ans_err;
         if (kind == CMD_SELECT) begin
            ctx_active[ch] <= 1'b0;
            ctx_done[ch]   <= 1'b0;
         end else if (!ans_err) begin
            if (first_blk) begin
               ctx_tag[ch]    <= full_tag;
               ctx_len[ch]    <= (kind == CMD_STORE) ? len_val : 24'hFFFFFF;
               ctx_off[ch]    <= 24'(vcnt);
               ctx_active[ch] <= next_sw != SW_OK;
               ctx_done[ch]   <= next_sw == SW_OK;
            end else if (p2_q[BLK_POS+1:BLK_POS] != BLK_RETX) begin
               ctx_off[ch]    <= new_off;
               ctx_active[ch] <= next_sw != SW_OK;
               ctx_done[ch]   <= next_sw == SW_OK;
            end
         end
      end
   end

   // Registered answer
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         sw_valid_out        <= 1'b0;
         sw_out              <= SW_OK;
         obj_tag_out         <= 24'h0;
         obj_len_out         <= 24'h0;
         obj_constructed_out <= 1'b0;
         tag_list_out        <= 1'b0;
      end else begin
         sw_valid_out <= state == ST_ANS;
         if (state == ST_ANS) begin
            sw_out              <= next_sw;
            obj_tag_out         <= first_blk ? full_tag : ctx_tag[ch];
            obj_len_out         <= len_val;
            obj_constructed_out <= full_tag[21];
            tag_list_out        <= first_blk && is_list && kind == CMD_RETRIEVE;
         end
      end
   end

   a_err_keeps_off: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (state == ST_ANS && ans_err && kind != CMD_SELECT) |=> $stable(ctx_off[ch]))
      else $error("offset moved on error");
   a_ans_one: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (state == ST_ANS) |=> sw_valid_out ##1 !sw_valid_out)
      else $error("strobe not one cycle");
   a_done_next: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (state == ST_ANS && ctx_done[ch] && !first_blk && kind == CMD_STORE &&
       p2_q[7:6] == BLK_NEXT && p2_q[4:0] == SFI_CUR) |=> sw_out == SW_DONE_NEXT)
      else $error("next after done accepted");
   a_unsup: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (state == ST_IDLE && cmd_valid_in && !cmd_app_ok_in) |=> state == ST_ANS)
      else $error("unsupported command executed");
   a_kit_hdr: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (state == ST_ANS && kit_err && kind != CMD_OTHER) |=> sw_out == SW_BAD_P1P2)
      else $error("bad header accepted");
endmodule : tlv_cmd_decoder
`default_nettype wire

// [testbench/tlv_terminal_model.sv]
// Purpose: terminal side, streams command data bytes and drains payload
// Assumes: bench loads q no later than the header strobe
// Notes:   released data line shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module tlv_terminal_model (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       nrst_in,
   // Command data
   output logic            data_valid_out,
   input  wire logic       data_ready_in,
   output logic [7:0]      data_out,
   // Payload drain
   input  wire logic       kit_hold_in,
   output logic            kit_ready_out
);
   logic [7:0] q[$];
   logic [7:0] last;
   int         seed;
   // ====================
   // Byte stream, held until taken
   initial begin
      data_valid_out = 1'b0;
      data_out = 8'h00;
      kit_ready_out = 1'b0;
      last = 8'h00;
      seed = 32'h0051;
   end
   always @(posedge mclk_in) begin
      if (data_valid_out === 1'b1 && data_ready_in === 1'b1) begin
         last = q.pop_front();
      end
      #1;
      data_valid_out = nrst_in && q.size() != 0;
      data_out = data_valid_out ? q[0] : ~last;
      kit_ready_out = !kit_hold_in && ($random(seed) & 3) != 0;
   end
endmodule : tlv_terminal_model
`default_nettype wire

// [testbench/toolkit_cmds_and_tlv_segmented_transfer_test.sv]
// Purpose: self-checking bench for the toolkit and object transfer decoder
// Assumes: one header per answer, partner streams the data bytes
// Notes:   fixed seed, corner cases mixed with random stores
`timescale 1ns/1ns
`default_nettype none
module toolkit_cmds_and_tlv_segmented_transfer_test;
   import tlv_cmd_pkg::*;
   typedef logic [7:0] bq_t[$];
   logic mclk_in = 1'b0, nrst_in = 1'b0, cmd_valid_in = 1'b0, has_lc = 1'b0;
   logic has_le = 1'b0, app_ok = 1'b1, pend = 1'b0, hold = 1'b0;
   cmd_kind_t kind = CMD_OTHER;
   logic [1:0] chan = 2'h0;
   logic [7:0] p1 = 8'h00, p2 = 8'h00, lc = 8'h00, data, kit_data, t;
   logic data_valid, data_ready, kit_valid, kit_ready, sw_valid, cons, tlist;
   logic [15:0] sw;
   logic [23:0] tag, len;
   bq_t b, kit_exp;
   int seed = 32'hBB2A, failures = 0, checks = 0, cycles = 0, n;
   // ====================
   // Design and terminal
   tlv_cmd_decoder #(.CHANNELS(4), .FIFO_DEPTH(8)) dut (.mclk_in(mclk_in),
      .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in), .cmd_kind_in(kind),
      .cmd_chan_in(chan), .cmd_p1_in(p1), .cmd_p2_in(p2), .cmd_has_lc_in(has_lc),
      .cmd_lc_in(lc), .cmd_has_le_in(has_le), .cmd_app_ok_in(app_ok),
      .proactive_pending_in(pend), .data_valid_in(data_valid),
      .data_ready_out(data_ready), .data_in(data), .kit_valid_out(kit_valid),
      .kit_ready_in(kit_ready), .kit_data_out(kit_data), .sw_valid_out(sw_valid),
      .sw_out(sw), .obj_tag_out(tag), .obj_len_out(len),
      .obj_constructed_out(cons), .tag_list_out(tlist));
   tlv_terminal_model term (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .data_valid_out(data_valid), .data_ready_in(data_ready), .data_out(data),
      .kit_hold_in(hold), .kit_ready_out(kit_ready));
   always #2 mclk_in = ~mclk_in;
   // ====================
   // Checking and closing
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   always @(posedge mclk_in) begin
      if (kit_valid === 1'b1 && kit_ready === 1'b1) begin
         chk({16'h0000, kit_data}, {16'h0000, kit_exp.pop_front()});
      end
      if (++cycles > 20000) begin
         failures++;
         complete_run();
      end
   end
   // ====================
   // One command: header, data via terminal, answer
   function automatic bq_t der(input int v);
      if (v < 128) return '{v[7:0]};
      if (v < 256) return '{8'h81, v[7:0]};
      return '{8'h82, v[15:8], v[7:0]};
   endfunction : der
   task automatic run(input cmd_kind_t k, input logic [1:0] ch, input logic [7:0] pb,
                      input logic [15:0] exp);
      int i;
      foreach (b[j]) term.q.push_back(b[j]);
      if (k <= CMD_TERM_RESP && exp == SW_OK) kit_exp = {kit_exp, b};
      kind = k;
      chan = ch;
      p2 = pb;
      has_lc = b.size() != 0;
      lc = 8'(b.size());
      has_le = k == CMD_FETCH || k == CMD_RETRIEVE;
      cmd_valid_in = 1'b1;
      @(posedge mclk_in);
      #1;
      cmd_valid_in = 1'b0;
      i = 0;
      while (sw_valid !== 1'b1 && i < 400) begin
         @(posedge mclk_in);
         #1;
         i++;
      end
      p1 = 8'h00;
      chk(24'(sw_valid), 24'h000001);
      if (exp != 16'h0000) chk(24'(sw), 24'(exp));
   endtask : run
   // ====================
   // Main sequence
   initial begin
      repeat (10) @(posedge mclk_in);
      #1;
      chk(24'(sw), 24'(SW_OK));
      nrst_in = 1'b1;
      hold = 1'b1;
      b = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
      fork
         begin
            repeat (40) @(posedge mclk_in);
            hold = 1'b0;
         end
      join_none
      run(CMD_ENVELOPE, 2'h0, 8'h00, SW_OK);
      b = {};
      p1 = 8'h01;
      run(CMD_ENVELOPE, 2'h0, 8'h00, SW_BAD_P1P2);
      pend = 1'b1;
      run(CMD_FETCH, 2'h0, 8'h00, SW_OK);
      run(CMD_FETCH, 2'h0, 8'h05, SW_BAD_P1P2);
      pend = 1'b0;
      run(CMD_PROFILE, 2'h0, 8'h01, SW_BAD_P1P2);
      b = '{8'h81, 8'h03};
      run(CMD_TERM_RESP, 2'h0, 8'h00, SW_OK);
      b = {};
      app_ok = 1'b0;
      run(CMD_STORE, 2'h0, 8'h80, SW_NO_INS);
      app_ok = 1'b1;
      b = '{8'h80, 8'h03, 8'h11};
      run(CMD_STORE, 2'h0, 8'h80, SW_MORE_EXP);
      b = '{8'h22, 8'h33};
      run(CMD_STORE, 2'h0, 8'h00, SW_OK);
      b = {};
      run(CMD_STORE, 2'h0, 8'h00, SW_DONE_NEXT);
      b = '{8'hA1, 8'h82, 8'h01, 8'h00, 8'h55};
      run(CMD_STORE, 2'h0, 8'h80, SW_MORE_EXP);
      chk(len, 24'h000100);
      chk({tag[23:8], 7'h00, cons}, 24'hA10001);
      b = '{8'h9F, 8'h10, 8'h01, 8'h00};
      run(CMD_STORE, 2'h0, 8'h80, SW_BAD_DATA);
      b = '{8'hBF, 8'h81, 8'h80, 8'h00};
      run(CMD_STORE, 2'h0, 8'h80, SW_BAD_DATA);
      b = '{8'h80, 8'h81, 8'h05};
      run(CMD_STORE, 2'h0, 8'h80, SW_BAD_DATA);
      b = '{8'h80, 8'h84, 8'h00};
      run(CMD_STORE, 2'h0, 8'h80, SW_BAD_DATA);
      b = '{8'h81, 8'h04, 8'hAA};
      run(CMD_STORE, 2'h1, 8'h80, SW_MORE_EXP);
      b = '{8'hCC};
      run(CMD_STORE, 2'h2, 8'h00, SW_NO_STATE);
      run(CMD_STORE, 2'h1, 8'h01, SW_BAD_P1P2);
      run(CMD_STORE, 2'h1, 8'h40, SW_NO_STATE);
      b = '{8'hBB, 8'hCC, 8'hDD};
      run(CMD_STORE, 2'h1, 8'h00, SW_OK);
      b = '{8'h82, 8'h05, 8'hAA};
      run(CMD_STORE, 2'h3, 8'h80, SW_MORE_EXP);
      b = {};
      run(CMD_SELECT, 2'h3, 8'h00, 16'h0000);
      b = '{8'h01};
      run(CMD_STORE, 2'h3, 8'h00, SW_NO_STATE);
      b = '{8'h83, 8'h05, 8'hAA};
      run(CMD_STORE, 2'h0, 8'h80, SW_MORE_EXP);
      b = '{8'h83, 8'h02, 8'hAA};
      run(CMD_STORE, 2'h0, 8'h80, SW_MORE_EXP);
      b = '{8'hBB};
      run(CMD_STORE, 2'h0, 8'h00, SW_OK);
      pend = 1'b1;
      b = '{8'hA0};
      run(CMD_RETRIEVE, 2'h2, 8'h80, SW_MORE_AVL_P);
      b = '{8'h5C};
      run(CMD_RETRIEVE, 2'h2, 8'h80, 16'h0000);
      chk(24'(tlist), 24'h000001);
      repeat (6) begin
         t = 8'h80 + 8'($unsigned($random(seed)) % 31);
         n = 2 + $unsigned($random(seed)) % 300;
         pend = $random(seed) & 1;
         b = {t, der(n), 8'hEE};
         run(CMD_STORE, 2'h1, 8'h80, pend ? SW_MORE_EXP_P : SW_MORE_EXP);
         chk(len, 24'(n));
      end
      repeat (60) @(posedge mclk_in);
      chk(24'(kit_exp.size()), 24'h000000);
      complete_run();
   end
endmodule : toolkit_cmds_and_tlv_segmented_transfer_test
`default_nettype wire
